// File: ckirq_pkg.sv
// constants for the ID-pin interrupt block: register map, field layout, timing
// assumes one 10 MHz clock shared by the register port and the event logic
// How it works
// RL1: id going open raises alt_int when the open-rise enable is set.
// RL2: id leaving open raises alt_int when the open-fall enable is set.
// RL3: link turns on the id pull-up before trusting open detection.
// RL4: unimplemented kit detect and plus-line bits read zero, writes ignored.
// RL5: measurement done raises alt_int when the done-interrupt enable is set.
// RL6: done-interrupt enable is local bit 5 OR the vendor register enable.
// RL7: enable register: 1dh writes, 1eh sets, 1fh clears; all three read it.
// RL8: reserved bits read zero; all implemented bits reset to zero.
// RL9: status bit 0 shows live id open state, gated by the pull-up.
// RL10: status bits 5:3 show the measured resistance code.
// RL11: status bit 6 sets when a 282 us measurement finishes.
// RL12: done flag clears only on a vendor-register read of the code.
// RL13: status register at 20h is read only, writes do nothing.
// RL14: latch bit 0 sets on an id change whose direction is enabled.
// RL15: latch bit 3 sets on done rising while done interrupt is enabled.
// RL16: latch register at 21h is read only and clears on read.
// RL17: link starts measurement via vendor go bit; it self-clears on completion.
// RL18: an event landing in a latch read cycle stays latched for next read.
package ckirq_pkg;
    localparam logic [5:0] CKIRQ_ADDR_EN_WR  = 6'h1d;
    localparam logic [5:0] CKIRQ_ADDR_EN_SET = 6'h1e;
    localparam logic [5:0] CKIRQ_ADDR_EN_CLR = 6'h1f;
    localparam logic [5:0] CKIRQ_ADDR_STATUS = 6'h20;
    localparam logic [5:0] CKIRQ_ADDR_LATCH  = 6'h21;

    localparam logic [7:0] CKIRQ_EN_MASK    = 8'h23;
    localparam logic [7:0] CKIRQ_RESET_BYTE = 8'h00;

    localparam int CKIRQ_EN_RISE_BIT = 0;
    localparam int CKIRQ_EN_FALL_BIT = 1;
    localparam int CKIRQ_EN_DONE_BIT = 5;
    localparam int CKIRQ_ST_OPEN_BIT = 0;
    localparam int CKIRQ_ST_CODE_LO  = 3;
    localparam int CKIRQ_ST_DONE_BIT = 6;
    localparam int CKIRQ_LT_ID_BIT   = 0;
    localparam int CKIRQ_LT_DONE_BIT = 3;

    localparam int CKIRQ_CLK_KHZ       = 10000;
    localparam int CKIRQ_MEASURE_US    = 282;
    localparam int CKIRQ_MEASURE_CYCLES = (CKIRQ_MEASURE_US * CKIRQ_CLK_KHZ + 999) / 1000;
    localparam int CKIRQ_CNT_W         = 12;
endpackage

// File: ckirq_measure_timer.sv
// resistance measurement timer: runs the fixed conversion time and samples the code
// assumes i_code is already synchronised and settled by the end of the conversion
`timescale 1ns/100ps
module ckirq_measure_timer (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // control
    input  wire logic       i_start,
    input  wire logic [2:0] i_code,
    // result
    output logic            o_busy,
    output logic            o_finish,
    output logic [2:0]      o_code
);
    logic [ckirq_pkg::CKIRQ_CNT_W-1:0] cnt_reg, cnt_next;
    logic                              busy_reg, busy_next;
    logic                              finish_reg, finish_next;
    logic [2:0]                        code_reg, code_next;

    localparam logic [ckirq_pkg::CKIRQ_CNT_W-1:0] LAST =
        ckirq_pkg::CKIRQ_CNT_W'(ckirq_pkg::CKIRQ_MEASURE_CYCLES - 1);

    always_comb begin
        cnt_next    = cnt_reg;
        busy_next   = busy_reg;
        finish_next = 1'b0;
        code_next   = code_reg;
        if (busy_reg) begin
            if (cnt_reg == LAST) begin
                busy_next   = 1'b0; // RL17
                finish_next = 1'b1; // RL11
                code_next   = i_code;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end else if (i_start) begin
            // a start while busy is ignored; restart would hide the pending result
            busy_next = 1'b1;
            cnt_next  = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_reg    <= '0;
            busy_reg   <= 1'b0;
            finish_reg <= 1'b0;
            code_reg   <= 3'h0;
        end else begin
            cnt_reg    <= cnt_next;
            busy_reg   <= busy_next;
            finish_reg <= finish_next;
            code_reg   <= code_next;
        end
    end

    assign o_busy   = busy_reg;
    assign o_finish = finish_reg;
    assign o_code   = code_reg;
endmodule

// File: ckirq_top.sv
// id-pin interrupt block: enable, status and latch registers plus alt_int flag
// assumes register port strobes are one-cycle pulses in this clock domain
`timescale 1ns/100ps
module ckirq_top (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // register port
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [5:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic [7:0]      o_reg_rdata,
    // id pin and otg control
    input  wire logic       i_id_open_pin,
    input  wire logic       i_id_line_pullup_on,
    // vendor conversion register hooks
    input  wire logic       i_resistance_measure_go,
    input  wire logic       i_vendor_irq_enable,
    input  wire logic       i_vendor_code_read,
    input  wire logic [2:0] i_resistance_code_raw,
    output logic            o_resistance_measure_busy,
    output logic            o_resistance_measure_done,
    output logic [2:0]      o_resistance_code,
    // rxcmd
    output logic            o_alt_int
);
    logic [1:0] id_sync_reg;
    logic [2:0] code_sync0_reg, code_sync1_reg;
    logic       id_open_prev_reg, id_open_prev_next;
    logic [7:0] enable_reg, enable_next;
    logic       done_reg, done_next;
    logic       done_prev_reg, done_prev_next;
    logic       latch_id_reg, latch_id_next;
    logic       latch_done_reg, latch_done_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       alt_int_reg, alt_int_next;
    logic       busy_reg;
    logic [2:0] code_reg;

    logic       timer_busy, timer_finish;
    logic [2:0] timer_code;
    logic       id_open_state;
    logic       id_rise_ev, id_fall_ev, id_ev, done_ev, done_irq_on;
    logic [7:0] status_byte, latch_byte;

    ckirq_measure_timer u_timer (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_start  (i_resistance_measure_go),
        .i_code   (code_sync1_reg),
        .o_busy   (timer_busy),
        .o_finish (timer_finish),
        .o_code   (timer_code)
    );

    // pin and analog code come from outside the clock domain
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            id_sync_reg    <= 2'h0;
            code_sync0_reg <= 3'h0;
            code_sync1_reg <= 3'h0;
        end else begin
            id_sync_reg    <= {id_sync_reg[0], i_id_open_pin};
            code_sync0_reg <= i_resistance_code_raw;
            code_sync1_reg <= code_sync0_reg;
        end
    end

    // open detection is meaningless without the pull-up, so gate it here
    assign id_open_state = id_sync_reg[1] & i_id_line_pullup_on; // RL9 RL3
    assign id_rise_ev = id_open_state & ~id_open_prev_reg;
    assign id_fall_ev = ~id_open_state & id_open_prev_reg;
    assign id_ev = (id_rise_ev & enable_reg[ckirq_pkg::CKIRQ_EN_RISE_BIT])   // RL1 RL14
                 | (id_fall_ev & enable_reg[ckirq_pkg::CKIRQ_EN_FALL_BIT]);  // RL2 RL14
    assign done_irq_on = enable_reg[ckirq_pkg::CKIRQ_EN_DONE_BIT] | i_vendor_irq_enable; // RL6
    assign done_ev = done_irq_on & done_reg & ~done_prev_reg; // RL5 RL15

    always_comb begin
        status_byte = ckirq_pkg::CKIRQ_RESET_BYTE; // RL4 RL8
        status_byte[ckirq_pkg::CKIRQ_ST_OPEN_BIT] = id_open_state;
        status_byte[ckirq_pkg::CKIRQ_ST_CODE_LO +: 3] = code_reg; // RL10
        status_byte[ckirq_pkg::CKIRQ_ST_DONE_BIT] = done_reg;
        latch_byte = ckirq_pkg::CKIRQ_RESET_BYTE; // RL4 RL8
        latch_byte[ckirq_pkg::CKIRQ_LT_ID_BIT]   = latch_id_reg;
        latch_byte[ckirq_pkg::CKIRQ_LT_DONE_BIT] = latch_done_reg;
    end

    always_comb begin
        enable_next       = enable_reg;
        id_open_prev_next = id_open_state;
        done_prev_next    = done_reg;
        // finish wins over a same-cycle vendor read
        done_next = timer_finish | (done_reg & ~i_vendor_code_read); // RL11 RL12
        latch_id_next   = latch_id_reg;
        latch_done_next = latch_done_reg;
        rdata_next      = rdata_reg;
        if (i_reg_wr) begin
            case (i_reg_addr)
                ckirq_pkg::CKIRQ_ADDR_EN_WR: begin
                    enable_next = i_reg_wdata & ckirq_pkg::CKIRQ_EN_MASK; // RL7 RL4
                end
                ckirq_pkg::CKIRQ_ADDR_EN_SET: begin
                    enable_next = enable_reg | (i_reg_wdata & ckirq_pkg::CKIRQ_EN_MASK); // RL7
                end
                ckirq_pkg::CKIRQ_ADDR_EN_CLR: begin
                    enable_next = enable_reg & ~i_reg_wdata; // RL7
                end
                default: begin
                    // status and latch ignore writes
                    enable_next = enable_reg; // RL13 RL16
                end
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                ckirq_pkg::CKIRQ_ADDR_EN_WR,
                ckirq_pkg::CKIRQ_ADDR_EN_SET,
                ckirq_pkg::CKIRQ_ADDR_EN_CLR: begin
                    rdata_next = enable_reg; // RL7
                end
                ckirq_pkg::CKIRQ_ADDR_STATUS: begin
                    rdata_next = status_byte; // RL12
                end
                ckirq_pkg::CKIRQ_ADDR_LATCH: begin
                    rdata_next      = latch_byte;
                    latch_id_next   = 1'b0; // RL16
                    latch_done_next = 1'b0; // RL16
                end
                default: begin
                    rdata_next = ckirq_pkg::CKIRQ_RESET_BYTE;
                end
            endcase
        end
        // applied after the read clear so a colliding event survives
        if (id_ev) begin
            latch_id_next = 1'b1; // RL14 RL18
        end
        if (done_ev) begin
            latch_done_next = 1'b1; // RL15 RL18
        end
        alt_int_next = id_ev | done_ev; // RL1 RL2 RL5
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            enable_reg       <= ckirq_pkg::CKIRQ_RESET_BYTE; // RL8
            id_open_prev_reg <= 1'b0;
            done_reg         <= 1'b0;
            done_prev_reg    <= 1'b0;
            latch_id_reg     <= 1'b0;
            latch_done_reg   <= 1'b0;
            rdata_reg        <= ckirq_pkg::CKIRQ_RESET_BYTE;
            alt_int_reg      <= 1'b0;
            busy_reg         <= 1'b0;
            code_reg         <= 3'h0;
        end else begin
            enable_reg       <= enable_next;
            id_open_prev_reg <= id_open_prev_next;
            done_reg         <= done_next;
            done_prev_reg    <= done_prev_next;
            latch_id_reg     <= latch_id_next;
            latch_done_reg   <= latch_done_next;
            rdata_reg        <= rdata_next;
            alt_int_reg      <= alt_int_next;
            busy_reg         <= timer_busy; // RL17
            code_reg         <= timer_code;
        end
    end

    assign o_reg_rdata               = rdata_reg;
    assign o_alt_int                 = alt_int_reg;
    assign o_resistance_measure_busy = busy_reg;
    assign o_resistance_measure_done = done_reg;
    assign o_resistance_code         = code_reg;
endmodule

// File: ckirq_link_model.sv
// link-side model: owns the vendor go bit and the vendor code read
// assumes the testbench requests with one-cycle pulses on i_start_req and i_read_req
`timescale 1ns/100ps
module ckirq_link_model (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // requests from the testbench, busy from the block
    input  wire logic i_start_req,
    input  wire logic i_read_req,
    input  wire logic i_busy,
    // go and code read to the block, go bit back to the testbench
    output logic      o_go = 1'h0,
    output logic      o_code_read = 1'h0,
    output logic      o_go_bit = 1'h0
);
    logic busy_q = 1'h0;
    always @(posedge i_clk) begin
        busy_q <= i_busy;
        o_go <= i_rst_n && i_start_req && !o_go_bit;
        o_code_read <= i_rst_n && i_read_req;
        // go bit self-clears when the conversion ends
        if (!i_rst_n || (busy_q && !i_busy)) begin
            o_go_bit <= 1'h0;
        end else if (i_start_req) begin
            o_go_bit <= 1'h1;
        end
    end
endmodule

// File: ckirq_assertions.sv
// port-level checker for the id-pin interrupt block
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/100ps
module ckirq_assertions (
    // all top ports, observed only
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       i_id_open_pin,
    input wire logic       i_id_line_pullup_on,
    input wire logic       i_resistance_measure_go,
    input wire logic       i_vendor_irq_enable,
    input wire logic       i_vendor_code_read,
    input wire logic [2:0] i_resistance_code_raw,
    input wire logic       o_resistance_measure_busy,
    input wire logic       o_resistance_measure_done,
    input wire logic [2:0] o_resistance_code,
    input wire logic       o_alt_int
);
    logic [11:0] busy_cnt_reg;
    logic [11:0] busy_cnt_next;
    always_comb busy_cnt_next = o_resistance_measure_busy ? busy_cnt_reg + 12'h001 : 12'h000;
    always_ff @(posedge i_clk) busy_cnt_reg <= i_rst_n ? busy_cnt_next : 12'h000;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_EN_RSVD: assert property (i_reg_rd && i_reg_addr inside {6'h1d, 6'h1e, 6'h1f}
        |=> (o_reg_rdata & 8'hdc) == 8'h00) else $error("enable reserved bits set");
    AST_ST_RSVD: assert property (i_reg_rd && i_reg_addr == 6'h20
        |=> !o_reg_rdata[7] && o_reg_rdata[2:1] == 2'h0) else $error("status reserved set");
    AST_ST_FIELDS: assert property (i_reg_rd && i_reg_addr == 6'h20
        |=> o_reg_rdata[5:3] == $past(o_resistance_code)
        && o_reg_rdata[6] == $past(o_resistance_measure_done)) else $error("status fields");
    AST_LT_RSVD: assert property (i_reg_rd && i_reg_addr == 6'h21
        |=> (o_reg_rdata & 8'hf6) == 8'h00) else $error("latch reserved bits set");
    AST_OPEN_GATE: assert property (i_reg_rd && i_reg_addr == 6'h20 && !i_id_line_pullup_on
        && !$past(i_id_line_pullup_on) |=> !o_reg_rdata[0]) else $error("open without pull-up");
    AST_GO_BUSY: assert property (i_resistance_measure_go && !o_resistance_measure_busy
        |-> ##2 o_resistance_measure_busy) else $error("go did not start conversion");
    AST_BUSY_LEN: assert property ($fell(o_resistance_measure_busy)
        |-> busy_cnt_reg inside {[12'hb03:12'hb05]}) else $error("conversion length wrong");
    AST_DONE_AFTER: assert property ($fell(o_resistance_measure_busy)
        |-> ##[0:2] o_resistance_measure_done) else $error("done missing after conversion");
    AST_DONE_HOLD: assert property (o_resistance_measure_done && !i_vendor_code_read
        |=> o_resistance_measure_done) else $error("done cleared without vendor read");
    AST_DONE_IRQ: assert property ($rose(o_resistance_measure_done) && i_vendor_irq_enable
        |=> o_alt_int) else $error("no alt_int on done");
endmodule
bind ckirq_top ckirq_assertions chk_i (.*);

// File: tb_carkit_id_interrupt_logic.sv
// self-checking bench for the id-pin interrupt block with a link-side model
// assumes ckirq_top, ckirq_link_model and the checker are compiled first
`timescale 1ns/100ps
module tb_carkit_id_interrupt_logic;
    logic       i_clk = 1'h0, i_rst_n = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
    logic [5:0] i_reg_addr = 6'h00;
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
    logic       i_id_open_pin = 1'h0, i_id_line_pullup_on = 1'h0, i_vendor_irq_enable = 1'h0;
    logic       i_resistance_measure_go, i_vendor_code_read, o_resistance_measure_busy;
    logic       o_resistance_measure_done, o_alt_int, go_bit;
    logic       start_req = 1'h0, read_req = 1'h0;
    logic [2:0] i_resistance_code_raw = 3'h0, o_resistance_code;
    int         failures = 0, n_compared = 0, n_alt = 0;
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_alt_int === 1'h1) n_alt <= n_alt + 1;
    ckirq_top uut (.*);
    ckirq_link_model link (.i_clk, .i_rst_n, .i_start_req(start_req), .i_read_req(read_req),
        .i_busy(o_resistance_measure_busy), .o_go(i_resistance_measure_go),
        .o_code_read(i_vendor_code_read), .o_go_bit(go_bit));
    task automatic final_report;
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #10;
    endtask
    // one cycle idle after each access keeps strobes from re-rising in one step
    task automatic reg_op(input logic wr, input logic [5:0] a, input logic [7:0] d);
        i_reg_wr = wr;
        i_reg_rd = !wr;
        i_reg_addr = a;
        i_reg_wdata = d;
        step(1);
        i_reg_wr = 1'h0;
        i_reg_rd = 1'h0;
        step(1);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        reg_op(1'h0, a, 8'h00);
        chk(o_reg_rdata, exp);
    endtask
    task automatic t_regs;
        rd(6'h1d, 8'h00);
        rd(6'h20, 8'h00);
        rd(6'h21, 8'h00);
        rd(6'h3f, 8'h00);
        reg_op(1'h1, 6'h1d, 8'hff);
        rd(6'h1d, 8'h23);
        reg_op(1'h1, 6'h1f, 8'h01);
        rd(6'h1e, 8'h22);
        reg_op(1'h1, 6'h1e, 8'h01);
        rd(6'h1f, 8'h23);
        reg_op(1'h1, 6'h20, 8'hff);
        rd(6'h20, 8'h00);
        reg_op(1'h1, 6'h21, 8'hff);
        rd(6'h21, 8'h00);
    endtask
    task automatic id_step(input logic lvl, input logic [7:0] exp);
        int a;
        a = n_alt;
        i_id_open_pin = lvl;
        step(8);
        chk(8'(n_alt - a), {7'h00, exp[0]});
        rd(6'h21, exp);
    endtask
    task automatic t_id;
        i_id_line_pullup_on = 1'h1;
        reg_op(1'h1, 6'h1d, 8'h01);
        id_step(1'h1, 8'h01);
        rd(6'h20, 8'h01);
        id_step(1'h0, 8'h00);
        reg_op(1'h1, 6'h1d, 8'h02);
        id_step(1'h1, 8'h00);
        id_step(1'h0, 8'h01);
        // event lands in the same cycle as the latch read
        reg_op(1'h1, 6'h1d, 8'h01);
        i_id_open_pin = 1'h1;
        step(2);
        rd(6'h21, 8'h00);
        rd(6'h21, 8'h01);
        id_step(1'h0, 8'h00);
        i_id_line_pullup_on = 1'h0;
        id_step(1'h1, 8'h00);
        rd(6'h20, 8'h00);
        i_id_open_pin = 1'h0;
    endtask
    task automatic measure(input logic [2:0] code, input logic en5, input logic ven);
        int a;
        int k;
        reg_op(1'h1, 6'h1d, {2'h0, en5, 5'h00});
        i_vendor_irq_enable = ven;
        i_resistance_code_raw = code;
        a = n_alt;
        start_req = 1'h1;
        step(1);
        start_req = 1'h0;
        step(3);
        chk({7'h00, o_resistance_measure_busy}, 8'h01);
        for (k = 0; k < 3000 && o_resistance_measure_done !== 1'h1; k++) step(1);
        if (k == 3000) begin
            failures++;
            final_report();
        end
        chk(8'(k + 1 - ckirq_pkg::CKIRQ_MEASURE_CYCLES), 8'h00);
        step(2);
        chk({7'h00, o_resistance_measure_busy}, 8'h00);
        chk({5'h00, o_resistance_code}, {5'h00, code});
        chk(8'(n_alt - a), {7'h00, en5 | ven});
        rd(6'h20, {2'h1, code, 3'h0});
        rd(6'h20, {2'h1, code, 3'h0});
        rd(6'h21, {4'h0, en5 | ven, 3'h0});
        chk({7'h00, go_bit}, 8'h00);
        read_req = 1'h1;
        step(1);
        read_req = 1'h0;
        step(2);
        chk({7'h00, o_resistance_measure_done}, 8'h00);
    endtask
    initial begin
        step(5);
        i_rst_n = 1'h1;
        t_regs();
        t_id();
        for (int i = 0; i < 7; i++) begin
            measure((i == 6) ? 3'h7 : 3'(i), i[0], i[1]);
        end
        final_report();
    end
endmodule
